/* File: logic/pir_pkg.sv */
// Shared constants for the paced interrupt router
package pir_pkg;
  // Condition groups and counts
  localparam int unsigned GRP_W        = 16;
  localparam int unsigned NUM_GRP      = 6;
  localparam int unsigned NUM_COND     = 96;
  localparam int unsigned NUM_DB_COND  = 64;
  localparam logic [2:0]  GRP_LSU      = 3'h4;
  localparam logic [2:0]  GRP_ERR      = 3'h5;
  localparam int unsigned ERR_BASE     = 80;
  localparam int unsigned ERR_LIM_BASE = 84;
  localparam int unsigned NUM_PORTS    = 4;
  // Output lines
  localparam int unsigned NUM_GP_LINES = 16;
  localparam int unsigned NUM_LINES    = 24;
  localparam int unsigned STARVE_LINE  = 24;
  localparam logic [4:0]  DB_LINE_BASE = 5'h10;
  // Routing field: [4] enable, [3:0] line
  localparam int unsigned ROUTE_W      = 5;
  localparam int unsigned ROUTE_EN_BIT = 4;
  localparam logic [4:0]  ROUTE_RST    = 5'h00;
  // Doorbell info field: [3:0] bit, [5:4] register, [15:6] reserved
  localparam int unsigned DB_IDX_MSB   = 5;
  localparam int unsigned DB_RSV_LSB   = 6;
  // Pacing counter
  localparam int unsigned PACE_W       = 16;
  localparam logic [15:0] PACE_RST     = 16'h0000;
  // Link error counters and outstanding write tracker
  localparam int unsigned ERRCNT_W     = 8;
  localparam logic [7:0]  ERRCNT_MAX   = 8'hFF;
  localparam int unsigned OUTST_W      = 8;
  // Run count at the last of the four consecutive reset-device symbols needed
  localparam logic [2:0]  RST_SYM_LAST = 3'h3;
endpackage

/* File: logic/pir_pace.sv */
// Per-line interrupt pacing down-counter and single-cycle pulse generator
module pir_pace
  import pir_pkg::*;
(
  // Clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_srst,
  // Pace count write
  input  wire logic              i_load,
  input  wire logic [PACE_W-1:0] i_value,
  input  wire logic              i_bypass,
  // Condition view
  input  wire logic              i_pending,
  input  wire logic              i_trigger,
  // Line output
  output logic                   o_pulse
);
  logic [PACE_W-1:0] count;
  logic              armed;
  wire logic         at_zero;
  wire logic         fire;

  // Paced lines fire once at zero; bypassed lines fire on each new condition
  assign at_zero = (count == PACE_RST);
  assign fire    = i_bypass ? i_trigger : (armed && at_zero && i_pending);

  // Counter reload, countdown and single-shot arming
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      count   <= PACE_RST;
      armed   <= 1'b0;
      o_pulse <= 1'b0;
    end else begin
      o_pulse <= fire;
      if (i_load) begin
        count <= i_value;
        armed <= 1'b1;
      end else begin
        if (!at_zero) begin
          count <= count - 16'h0001;
        end
        if (fire) begin
          armed <= 1'b0;
        end
      end
    end
  end
endmodule

/* File: logic/pir_router.sv */
// Interrupt handling unit: condition status, routing, decode, pacing and link events
module pir_router
  import pir_pkg::*;
(
  // Clock and reset
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_srst,
  // Incoming doorbells
  input  wire logic                 i_db_valid,
  input  wire logic [15:0]          i_db_info,
  // Data write tracking
  input  wire logic                 i_xfer_submit,
  input  wire logic                 i_xfer_done,
  // Load/store unit events
  input  wire logic [GRP_W-1:0]     i_lsu_event,
  // Link error reporting
  input  wire logic [NUM_PORTS-1:0] i_link_err,
  input  wire logic [ERRCNT_W-1:0]  i_err_threshold,
  input  wire logic [NUM_PORTS-1:0] i_port_degraded,
  input  wire logic [NUM_PORTS-1:0] i_port_failed,
  input  wire logic                 i_pw_enable,
  // Control symbols
  input  wire logic                 i_rst_sym,
  input  wire logic                 i_other_sym,
  // Packet DMA starvation
  input  wire logic                 i_starve_event,
  // Condition route write
  input  wire logic                 i_route_wr,
  input  wire logic [6:0]           i_route_idx,
  input  wire logic [ROUTE_W-1:0]   i_route_data,
  // Condition status write and clear
  input  wire logic                 i_stat_wr,
  input  wire logic [2:0]           i_stat_grp,
  input  wire logic [GRP_W-1:0]     i_stat_data,
  input  wire logic                 i_clr_wr,
  input  wire logic [2:0]           i_clr_grp,
  input  wire logic [GRP_W-1:0]     i_clr_data,
  // Line control
  input  wire logic                 i_db_dedicated,
  input  wire logic                 i_pace_wr,
  input  wire logic [3:0]           i_pace_line,
  input  wire logic [PACE_W-1:0]    i_pace_data,
  input  wire logic [15:0]          i_pace_dis,
  input  wire logic [4:0]           i_dec_sel,
  // Interrupt lines
  output logic [NUM_LINES-1:0]      o_int_line,
  output logic                      o_starve_int,
  // Link answers
  output logic                      o_db_err,
  output logic                      o_port_write,
  output logic                      o_remote_reset,
  // Readback
  output logic [NUM_COND-1:0]       o_condition_status,
  output logic [7:0]                o_line_source_decode
);

  // Place a 16-bit group word at its slot in the condition vector
  function automatic logic [NUM_COND-1:0] spread(input logic [2:0] g, input logic [GRP_W-1:0] d);
    logic [NUM_COND-1:0] r;
    r = {80'h0, d} << ({4'h0, g} << 4);
    return r;
  endfunction

  // Lowest set condition as {valid, group, bit}
  function automatic logic [7:0] first_set(input logic [NUM_COND-1:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = NUM_COND - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 7'(i)};
      end
    end
    return r;
  endfunction

  // Output line of a routing field, doorbells steered to the dedicated lines
  function automatic logic [4:0] line_of(input logic is_db, input logic dedicated, input logic [ROUTE_W-1:0] f);
    logic [4:0] r;
    r = (is_db && dedicated) ? (DB_LINE_BASE | {2'b00, f[2:0]}) : {1'b0, f[3:0]};
    return r;
  endfunction

  logic [NUM_DB_COND-1:0] db_hold;
  logic [OUTST_W-1:0]     outstanding;
  logic [ERRCNT_W-1:0]    err_cnt [NUM_PORTS];
  logic [ROUTE_W-1:0]     route [NUM_COND];
  logic [NUM_COND-1:0]    status_prev;
  logic [NUM_LINES-1:0]   rearm;
  logic [2:0]             rst_sym_cnt;

  // Doorbell decode: reserved bits reject, else one of 64 bits
  wire logic                   db_rsv;
  wire logic                   db_ok;
  wire logic [NUM_DB_COND-1:0] db_in;
  wire logic                   db_release;
  wire logic [NUM_DB_COND-1:0] db_set;
  assign db_rsv     = |i_db_info[15:DB_RSV_LSB];
  assign db_ok      = i_db_valid && !db_rsv;
  assign db_in      = db_ok ? (64'h1 << i_db_info[DB_IDX_MSB:0]) : 64'h0;
  assign db_release = (outstanding == 8'h00);
  assign db_set     = db_release ? (db_hold | db_in) : 64'h0;

  // Link error threshold and limit conditions
  logic [NUM_PORTS-1:0] err_over;
  logic [NUM_PORTS-1:0] err_cross;
  wire  logic [GRP_W-1:0] err_clr_word;
  assign err_clr_word = (i_clr_wr && i_clr_grp == GRP_ERR) ? i_clr_data : 16'h0000;
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    wire logic [ERRCNT_W-1:0] cnt_inc;
    assign cnt_inc      = (err_cnt[p] == ERRCNT_MAX) ? err_cnt[p] : err_cnt[p] + 8'h01;
    assign err_over[p]  = err_cnt[p] > i_err_threshold;
    assign err_cross[p] = i_link_err[p] && !err_over[p] && (cnt_inc > i_err_threshold);

    // Per-port error counter, restarted when software clears its condition
    always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
        err_cnt[p] <= 8'h00;
      end else if (err_clr_word[p]) begin
        err_cnt[p] <= 8'h00;
      end else if (i_link_err[p]) begin
        err_cnt[p] <= cnt_inc;
      end
    end
  end

  // A cleared threshold flag is held off while its counter restarts
  wire logic [NUM_PORTS-1:0] err_flag;
  assign err_flag = (err_over & ~err_clr_word[NUM_PORTS-1:0]) | err_cross;

  // Hardware set vector for all groups
  wire logic [GRP_W-1:0]    err_word;
  wire logic [NUM_COND-1:0] set_vec;
  assign err_word = {8'h00, i_port_degraded | i_port_failed, err_flag};
  assign set_vec  = {err_word, i_lsu_event, db_set};

  // Software write and clear masks
  wire logic [NUM_COND-1:0] wr_sel;
  wire logic [NUM_COND-1:0] wr_val;
  wire logic [NUM_COND-1:0] clr_sel;
  wire logic [NUM_COND-1:0] next_status;
  wire logic [NUM_COND-1:0] new_bits;
  assign wr_sel      = i_stat_wr ? spread(i_stat_grp, 16'hFFFF) : 96'h0;
  assign wr_val      = spread(i_stat_grp, i_stat_data);
  assign clr_sel     = i_clr_wr ? spread(i_clr_grp, i_clr_data) : 96'h0;
  // Set wins over write and clear in the same cycle
  assign next_status = (((o_condition_status & ~wr_sel) | (wr_sel & wr_val)) & ~clr_sel) | set_vec;
  assign new_bits    = o_condition_status & ~status_prev;

  // Destination of each condition, doorbells steered by the control level
  logic [4:0]          dest [NUM_COND];
  logic [NUM_COND-1:0] routed;
  for (genvar c = 0; c < NUM_COND; c++) begin : g_dest
    assign dest[c]   = line_of(c < NUM_DB_COND, i_db_dedicated, route[c]);
    assign routed[c] = route[c][ROUTE_EN_BIT];
  end

  // Per-line mapped view of status
  logic [NUM_COND-1:0]  mapvec [NUM_LINES];
  logic [NUM_LINES-1:0] pending;
  logic [NUM_LINES-1:0] trigger;
  logic [NUM_LINES-1:0] line_pulse;
  for (genvar l = 0; l < NUM_LINES; l++) begin : g_line
    for (genvar c = 0; c < NUM_COND; c++) begin : g_map
      assign mapvec[l][c] = o_condition_status[c] && routed[c] && (dest[c] == 5'(l));
    end
    assign pending[l] = |mapvec[l];
    assign trigger[l] = |(mapvec[l] & new_bits) || (rearm[l] && pending[l]);

    if (l < NUM_GP_LINES) begin : g_gp
      pir_pace u_pace (
        .i_ref_clk (i_ref_clk),
        .i_srst    (i_srst),
        .i_load    (i_pace_wr && (i_pace_line == 4'(l))),
        .i_value   (i_pace_data),
        .i_bypass  (i_pace_dis[l]),
        .i_pending (pending[l]),
        .i_trigger (trigger[l]),
        .o_pulse   (line_pulse[l])
      );
    end else begin : g_dbl
      pir_pace u_pace (
        .i_ref_clk (i_ref_clk),
        .i_srst    (i_srst),
        .i_load    (1'b0),
        .i_value   (PACE_RST),
        .i_bypass  (1'b1),
        .i_pending (pending[l]),
        .i_trigger (trigger[l]),
        .o_pulse   (line_pulse[l])
      );
    end
  end
  // Line pulses come straight from the pulse flip-flops
  assign o_int_line = line_pulse;

  // Route enable target for re-evaluation
  wire logic [4:0] route_dest;
  wire logic       route_en_wr;
  assign route_en_wr = i_route_wr && (i_route_idx < 7'(NUM_COND)) && i_route_data[ROUTE_EN_BIT];
  assign route_dest  = line_of(i_route_idx < 7'(NUM_DB_COND), i_db_dedicated, i_route_data);

  // Decode readback selection
  wire logic [7:0] dec_value;
  assign dec_value = (i_dec_sel < 5'(NUM_LINES)) ? first_set(mapvec[i_dec_sel]) : 8'h00;

  // Routing table
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      for (int c = 0; c < NUM_COND; c++) begin
        route[c] <= ROUTE_RST;
      end
    end else if (i_route_wr && i_route_idx < 7'(NUM_COND)) begin
      route[i_route_idx] <= i_route_data;
    end
  end

  // Condition status register
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_condition_status <= 96'h0;
    end else begin
      o_condition_status <= next_status;
    end
  end

  // Previous status, so only newly set bits, or a route enable, trigger unpaced lines
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      status_prev <= 96'h0;
    end else begin
      status_prev <= o_condition_status;
    end
  end

  // One-cycle re-evaluation request for the line a route enable points at
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      rearm <= 24'h0;
    end else begin
      rearm <= route_en_wr ? (24'h1 << route_dest) : 24'h0;
    end
  end

  // Doorbells collected while data writes are still outstanding
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      db_hold <= 64'h0;
    end else begin
      db_hold <= db_release ? 64'h0 : (db_hold | db_in);
    end
  end

  // Submitted minus completed data writes
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      outstanding <= 8'h00;
    end else begin
      outstanding <= outstanding + {7'h00, i_xfer_submit} - {7'h00, i_xfer_done};
    end
  end

  // Error answer for a doorbell with reserved info bits
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_db_err <= 1'b0;
    end else begin
      o_db_err <= i_db_valid && db_rsv;
    end
  end

  // Run of reset-device symbols, restarted by any other symbol
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      rst_sym_cnt <= 3'h0;
    end else if (i_other_sym || (i_rst_sym && rst_sym_cnt == RST_SYM_LAST)) begin
      rst_sym_cnt <= 3'h0;
    end else if (i_rst_sym) begin
      rst_sym_cnt <= rst_sym_cnt + 3'h1;
    end
  end

  // Remote reset pulse on the fourth unbroken reset symbol
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_remote_reset <= 1'b0;
    end else begin
      o_remote_reset <= i_rst_sym && !i_other_sym && (rst_sym_cnt == RST_SYM_LAST);
    end
  end

  // Port-write request when a port first passes its threshold
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_port_write <= 1'b0;
    end else begin
      o_port_write <= i_pw_enable && (|err_cross);
    end
  end

  // Starvation line, a registered copy of its event
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_starve_int <= 1'b0;
    end else begin
      o_starve_int <= i_starve_event;
    end
  end

  // Decode readback of the selected line
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_line_source_decode <= 8'h00;
    end else begin
      o_line_source_decode <= dec_value;
    end
  end
endmodule

/* File: test/pir_router_checker.sv */
// Concurrent checks on the ports of the paced interrupt router
module pir_router_checker
  import pir_pkg::*;
(
  // Clock and reset
  input wire logic                 i_ref_clk,
  input wire logic                 i_srst,
  // Watched inputs
  input wire logic                 i_db_valid,
  input wire logic [15:0]          i_db_info,
  input wire logic [GRP_W-1:0]     i_lsu_event,
  input wire logic                 i_rst_sym,
  input wire logic                 i_other_sym,
  input wire logic                 i_starve_event,
  input wire logic                 i_stat_wr,
  input wire logic                 i_clr_wr,
  input wire logic [2:0]           i_clr_grp,
  input wire logic [GRP_W-1:0]     i_clr_data,
  input wire logic [4:0]           i_dec_sel,
  // Watched outputs
  input wire logic [NUM_LINES-1:0] o_int_line,
  input wire logic                 o_starve_int,
  input wire logic                 o_db_err,
  input wire logic                 o_remote_reset,
  input wire logic [NUM_COND-1:0]  o_condition_status,
  input wire logic [7:0]           o_line_source_decode
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  logic [2:0] sym_run;
  // Reset symbols seen in an unbroken run, wrapping after the fourth
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || i_other_sym) sym_run <= 3'h0;
    else if (i_rst_sym) sym_run <= (sym_run == RST_SYM_LAST) ? 3'h0 : sym_run + 3'h1;
  end
  chk_remote_count: assert property (o_remote_reset == ($past(i_rst_sym && !i_other_sym) && $past(sym_run) == RST_SYM_LAST))
    else $error("remote reset not on the fourth symbol");
  chk_pulse_single: assert property ((o_int_line != '0) |=> (o_int_line & $past(o_int_line)) == '0)
    else $error("interrupt line held longer than one cycle");
  chk_starve_copy: assert property (i_starve_event |=> o_starve_int)
    else $error("starvation event not passed on");
  chk_db_reserved: assert property (i_db_valid && (i_db_info[15:DB_RSV_LSB] != '0) |=> o_db_err)
    else $error("reserved doorbell bits not refused");
  chk_lsu_set: assert property (i_lsu_event[0] |=> o_condition_status[64])
    else $error("load store condition not recorded");
  chk_clear_bit: assert property (i_clr_wr && !i_stat_wr && i_clr_grp == GRP_LSU && i_clr_data[0] && !i_lsu_event[0]
    |=> !o_condition_status[64])
    else $error("cleared condition still set");
  chk_status_keep: assert property (!i_stat_wr && !i_clr_wr && o_condition_status[64] |=> o_condition_status[64])
    else $error("pending condition dropped");
  chk_decode_high: assert property (i_dec_sel >= 5'h18 |=> o_line_source_decode == 8'h00)
    else $error("decode of a missing line not zero");
endmodule

/* File: test/pir_cores_model.sv */
// Model of the cores on the interrupt lines, flagging any pulse that lasts too long
module pir_cores_model
  import pir_pkg::*;
(
  // Clock and reset
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_srst,
  // Interrupt lines from the router
  input  wire logic [NUM_LINES-1:0] i_int_line,
  // Width fault flag
  output logic                      o_wide
);
  logic [NUM_LINES-1:0] prev;
  // A core takes each rising line as one event; two high cycles in a row is a fault
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      prev <= '0;
      o_wide <= 1'b0;
    end else begin
      prev <= i_int_line;
      if ((i_int_line & prev) != '0) o_wide <= 1'b1;
    end
  end
endmodule

/* File: test/paced_interrupt_router_bench.sv */
// Self-checking bench for the paced interrupt router
module paced_interrupt_router_bench
  import pir_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic i_ref_clk, i_srst, i_db_valid, i_xfer_submit, i_xfer_done, i_pw_enable, i_rst_sym, i_other_sym;
  logic i_starve_event, i_route_wr, i_stat_wr, i_clr_wr, i_db_dedicated, i_pace_wr;
  logic [15:0] i_db_info, i_lsu_event, i_stat_data, i_clr_data, i_pace_data, i_pace_dis;
  logic [3:0] i_link_err, i_port_degraded, i_port_failed, i_pace_line, b, ln;
  logic [7:0] i_err_threshold, o_line_source_decode;
  logic [6:0] i_route_idx;
  logic [4:0] i_route_data, i_dec_sel;
  logic [2:0] i_stat_grp, i_clr_grp, x;
  logic [1:0] r;
  logic [23:0] o_int_line;
  logic [95:0] o_condition_status;
  logic o_starve_int, o_db_err, o_port_write, o_remote_reset, o_wide;
  logic [31:0] rng = 32'h38A8;
  int n_mismatch = 0, n_checks = 0, n_pw = 0, n_rr = 0, cycles = 0, first, cnt, c, t;

  pir_router DUT (.*);
  pir_cores_model u_cores (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_int_line(o_int_line), .o_wide(o_wide));

  // Clock generation
  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  // Link answer counts and run limit
  always @(negedge i_ref_clk) begin
    cycles++;
    if (!i_srst && o_port_write !== 1'b0) n_pw++;
    if (!i_srst && o_remote_reset !== 1'b0) n_rr++;
    if (cycles == 5000) begin
      n_mismatch++;
      finish_test();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic chk(input string name, input logic [95:0] seen, input logic [95:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Ends a one-cycle request: all strobes drop at the next falling edge
  task automatic step();
    @(negedge i_ref_clk);
    {i_db_valid, i_xfer_submit, i_xfer_done, i_rst_sym, i_other_sym, i_starve_event, i_route_wr, i_stat_wr,
     i_clr_wr, i_pace_wr, i_lsu_event, i_link_err} = '0;
  endtask

  task automatic strobe(input int w);
    @(negedge i_ref_clk);
    case (w)
      0: i_rst_sym = 1'b1;
      1: i_other_sym = 1'b1;
      2: i_xfer_submit = 1'b1;
      3: i_xfer_done = 1'b1;
      4: i_starve_event = 1'b1;
      default: i_link_err = 4'h1;
    endcase
    step();
  endtask

  task automatic word(input logic clear, input logic [2:0] g, input logic [15:0] d);
    @(negedge i_ref_clk);
    if (clear) {i_clr_wr, i_clr_grp, i_clr_data} = {1'b1, g, d};
    else {i_stat_wr, i_stat_grp, i_stat_data} = {1'b1, g, d};
    step();
  endtask

  task automatic route(input logic [6:0] idx, input logic [4:0] d);
    @(negedge i_ref_clk);
    {i_route_wr, i_route_idx, i_route_data} = {1'b1, idx, d};
    step();
  endtask

  task automatic pace(input logic [3:0] l, input logic [15:0] d);
    @(negedge i_ref_clk);
    {i_pace_wr, i_pace_line, i_pace_data} = {1'b1, l, d};
    step();
  endtask

  task automatic load_store_unit(input logic [3:0] n);
    @(negedge i_ref_clk);
    i_lsu_event = 16'h0001 << n;
    step();
  endtask

  task automatic db(input logic [15:0] info);
    @(negedge i_ref_clk);
    {i_db_valid, i_db_info} = {1'b1, info};
    step();
  endtask

  // Counts pulses on one line over n falling edges and notes the first
  task automatic watch(input int line, input int n);
    first = 0;
    cnt = 0;
    for (int i = 1; i <= n; i++) begin
      @(negedge i_ref_clk);
      if (o_int_line[line] !== 1'b0) begin
        cnt++;
        if (first == 0) first = i;
      end
    end
  endtask

  // Main sequence
  initial begin
    {i_db_valid, i_xfer_submit, i_xfer_done, i_pw_enable, i_rst_sym, i_other_sym, i_starve_event, i_route_wr,
     i_stat_wr, i_clr_wr, i_db_dedicated, i_pace_wr, i_db_info, i_lsu_event, i_stat_data, i_clr_data, i_pace_data,
     i_link_err, i_port_degraded, i_port_failed, i_pace_line, i_err_threshold, i_route_idx, i_route_data,
     i_dec_sel, i_stat_grp, i_clr_grp} = '0;
    i_pace_dis = 16'hFFFF;
    i_srst = 1'b1;
    repeat (4) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_srst = 1'b0;
    // Unpaced routing, re-evaluation on enable, decode and clear
    for (int it = 0; it < 4; it++) begin
      rng = xs(rng);
      b = (it == 0) ? 4'h0 : rng[3:0];
      ln = rng[7:4];
      word(1'b1, GRP_LSU, 16'hFFFF);
      load_store_unit(b);
      chk("status set", o_condition_status[64 + b], 1'b1);
      watch(ln, 3);
      chk("unrouted pulses", cnt, 0);
      route({3'h4, b}, {1'b1, ln});
      watch(ln, 3);
      chk("enable pulse time", first, 1);
      chk("enable pulse count", cnt, 1);
      @(negedge i_ref_clk);
      i_dec_sel = {1'b0, ln};
      @(negedge i_ref_clk);
      chk("source decode", o_line_source_decode, {1'b1, GRP_LSU, b});
      word(1'b1, GRP_LSU, 16'h0001 << b);
      chk("status cleared", o_condition_status[64 + b], 1'b0);
      route({3'h4, b}, 5'h00);
    end
    rng = xs(rng);
    word(1'b0, GRP_LSU, rng[15:0]);
    chk("forced status", o_condition_status[79:64], rng[15:0]);
    word(1'b1, GRP_LSU, 16'hFFFF);
    @(negedge i_ref_clk);
    i_dec_sel = 5'h18;
    @(negedge i_ref_clk);
    chk("decode beyond lines", o_line_source_decode, 8'h00);
    // Paced line: zero and random counts, single shot, same-value rewrite
    ln = rng[19:16];
    c = 1 + (rng[23:20] % 9);
    @(negedge i_ref_clk);
    i_pace_dis[ln] = 1'b0;
    route(7'h40, {1'b1, ln});
    load_store_unit(4'h0);
    for (int k = 0; k < 3; k++) begin
      pace(ln, (k == 0) ? 16'h0000 : 16'(c));
      watch(ln, 14);
      chk("paced delay", first, (k == 0) ? 1 : c + 1);
      chk("single pulse", cnt, 1);
      word(1'b1, GRP_LSU, 16'h0001);
      load_store_unit(4'h0);
      watch(ln, 6);
      chk("no repeat pulse", cnt, 0);
    end
    route(7'h40, 5'h00);
    @(negedge i_ref_clk);
    i_pace_dis = 16'hFFFF;
    // Doorbells on dedicated lines behind an outstanding write, then general lines
    rng = xs(rng);
    {x, r, b} = rng[8:0];
    i_db_dedicated = 1'b1;
    word(1'b1, {1'b0, r}, 16'h0001 << b);
    route({1'b0, r, b}, {2'b10, x});
    strobe(2);
    db({10'h000, r, b});
    watch(16 + x, 5);
    chk("doorbell held", cnt, 0);
    strobe(3);
    watch(16 + x, 6);
    chk("dedicated pulse", cnt, 1);
    chk("doorbell status", o_condition_status[{r, b}], 1'b1);
    @(negedge i_ref_clk);
    i_db_dedicated = 1'b0;
    word(1'b1, {1'b0, r}, 16'h0001 << b);
    db({10'h000, r, b});
    watch(x, 6);
    chk("general doorbell pulse", cnt, 1);
    db(16'h0040);
    chk("reserved bit error", o_db_err, 1'b1);
    // Reset symbols broken by another symbol, then a full run of four
    for (int k = 0; k < 7; k++) strobe((k == 3) ? 1 : 0);
    chk("broken run", n_rr, 0);
    strobe(0);
    @(negedge i_ref_clk);
    chk("remote reset", n_rr, 1);
    // Link errors over threshold, port-write, degraded port, starvation
    t = 1 + rng[10:9];
    @(negedge i_ref_clk);
    i_pw_enable = 1'b1;
    i_err_threshold = 8'(t);
    repeat (t) strobe(5);
    chk("under threshold", o_condition_status[80], 1'b0);
    strobe(5);
    @(negedge i_ref_clk);
    chk("over threshold", o_condition_status[80], 1'b1);
    i_port_degraded = 4'h2;
    @(negedge i_ref_clk);
    chk("degraded status", o_condition_status[85], 1'b1);
    chk("port write count", n_pw, 1);
    i_port_failed = 4'h4;
    strobe(4);
    chk("starvation line", o_starve_int, 1'b1);
    chk("failed status", o_condition_status[86], 1'b1);
    word(1'b1, GRP_ERR, 16'h0001);
    chk("error cleared", o_condition_status[80], 1'b0);
    chk("pulse width", o_wide, 1'b0);
    finish_test();
  end
endmodule

bind pir_router pir_router_checker u_chk (.*);
